// ### hdl/chac_pkg.sv
// package: constants and types for the heater current alarm compare block
package chac_pkg;

    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned ON_MIN_MS      = 100;
    localparam int unsigned ON_MIN_CYCLES  = ON_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned FLASH_HALF_MS  = 250;
    localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);

    localparam int unsigned CUR_W = 10;
    localparam int unsigned TH_W  = 9;

    localparam logic [TH_W-1:0]  TH_MIN     = 9'h000;
    localparam logic [TH_W-1:0]  TH_MAX     = 9'h1F4;
    localparam logic [TH_W-1:0]  BO_TH_RST  = 9'h000;
    localparam logic [TH_W-1:0]  OC_TH_RST  = 9'h1F4;
    localparam logic [CUR_W-1:0] MON_LIMIT  = 10'h226;
    localparam logic [15:0]      MON_SAT    = 16'hFFFF;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_BO_TH1 = 8'h04;
    localparam logic [7:0] ADDR_BO_TH2 = 8'h08;
    localparam logic [7:0] ADDR_OC_TH1 = 8'h0C;
    localparam logic [7:0] ADDR_OC_TH2 = 8'h10;
    localparam logic [7:0] ADDR_MON1   = 8'h14;
    localparam logic [7:0] ADDR_MON2   = 8'h18;
    localparam logic [7:0] ADDR_ALARM  = 8'h1C;
    localparam logic [7:0] ADDR_ISTAT  = 8'h20;
    localparam logic [7:0] ADDR_IMASK  = 8'h24;

    localparam int unsigned CTRL_BO_EN = 0;
    localparam int unsigned CTRL_OC_EN = 1;
    localparam logic [1:0]  CTRL_RST   = 2'h0;
    localparam logic [3:0]  IMASK_RST  = 4'h0;

    // alarm flags, also the layout of status and mask
    typedef struct packed {
        logic oc2;
        logic bo2;
        logic oc1;
        logic bo1;
    } chac_alarm_t;

    typedef struct packed {
        logic [TH_W-1:0] bo;
        logic [TH_W-1:0] oc;
    } chac_thr_t;

endpackage

// ### hdl/chac_on_timer.sv
// heating output on-time measurement
`timescale 1ns/1ps
`default_nettype none
module chac_on_timer
    import chac_pkg::*;
#(
    parameter int unsigned MIN_CYC = ON_MIN_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic heat_on,
    output logic      long_enough
);
    logic [31:0] on_cnt;

    // counts cycles of the current on-pulse, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_cnt <= 32'h0;
        end else if (!heat_on) begin
            on_cnt <= 32'h0;
        end else if (on_cnt <= MIN_CYC) begin
            on_cnt <= on_cnt + 32'h1;
        end
    end

    // strictly longer than the minimum
    assign long_enough = heat_on && (on_cnt > MIN_CYC);
endmodule
`default_nettype wire

// ### hdl/chac_chan_cmp.sv
// one channel of burnout and overcurrent threshold comparison
`timescale 1ns/1ps
`default_nettype none
module chac_chan_cmp
    import chac_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [CUR_W-1:0] cur,
    input  wire chac_thr_t        thr,
    input  wire logic             bo_en,
    input  wire logic             oc_en,
    input  wire logic             eval,
    output logic                  bo_alarm,
    output logic                  oc_alarm
);
    logic [CUR_W-1:0] bo_w;
    logic [CUR_W-1:0] oc_w;

    assign bo_w = CUR_W'(thr.bo);
    assign oc_w = CUR_W'(thr.oc);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bo_alarm <= 1'b0;
        end else if (!bo_en) begin
            bo_alarm <= 1'b0;
        end else if (thr.bo == TH_MIN) begin
            bo_alarm <= 1'b0;
        end else if (thr.bo == TH_MAX) begin
            bo_alarm <= 1'b1;
        end else if (eval) begin
            bo_alarm <= (cur < bo_w);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_alarm <= 1'b0;
        end else if (!oc_en) begin
            oc_alarm <= 1'b0;
        end else if (thr.oc == TH_MAX) begin
            oc_alarm <= 1'b0;
        end else if (thr.oc == TH_MIN) begin
            oc_alarm <= 1'b1;
        end else if (eval) begin
            oc_alarm <= (cur > oc_w);
        end
    end
endmodule
`default_nettype wire

// ### hdl/chac_top.sv
// heater current alarm compare: apb registers, two channels, indicators
`timescale 1ns/1ps
`default_nettype none
module chac_top
    import chac_pkg::*;
#(
    parameter bit          TWO_CT     = 1'b1,
    parameter int unsigned ON_MIN_CYC = ON_MIN_CYCLES,
    parameter int unsigned FLASH_CYC  = FLASH_HALF_CYC
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic                  pslverr,
    output logic [31:0]           prdata,
    input  wire logic             sample_valid,
    input  wire logic [CUR_W-1:0] cur1,
    input  wire logic [CUR_W-1:0] cur2,
    input  wire logic             heat_on,
    output logic                  heater_alarm_lamp,
    output logic                  mon1_flash,
    output logic                  mon2_flash,
    output logic                  alarm_out,
    output logic                  irq
);

    // range clamp for written thresholds
    function automatic logic [TH_W-1:0] clamp_th(input logic [31:0] v);
        if (v > 32'(TH_MAX)) begin
            return TH_MAX;
        end
        return v[TH_W-1:0];
    endfunction

    // monitor value with saturation code
    function automatic logic [15:0] mon_val(input logic [CUR_W-1:0] c);
        if (c > MON_LIMIT) begin
            return MON_SAT;
        end
        return 16'(c);
    endfunction

    // write strobe for one register address
    function automatic logic wr_to(input logic acc, input logic [7:0] a, input logic [7:0] r);
        return acc && (a == r);
    endfunction

    logic [1:0]       ctrl;
    chac_thr_t        thr1;
    chac_thr_t        thr2;
    logic [CUR_W-1:0] cur1_q;
    logic [CUR_W-1:0] cur2_q;
    logic [15:0]      mon1;
    logic [15:0]      mon2;
    chac_alarm_t      alarm;
    chac_alarm_t      alarm_d;
    chac_alarm_t      istat;
    chac_alarm_t      imask;
    chac_alarm_t      rise;
    chac_alarm_t      w1c;
    logic             long_enough;
    logic             eval;
    logic             ch2_bo_en;
    logic             ch2_oc_en;
    logic             setup;
    logic             wr_acc;
    logic             hit;
    logic [31:0]      next_prdata;
    logic [31:0]      blink_cnt;
    logic             blink_wrap;
    logic             blink;

    // bus phases
    assign pready = 1'b1;
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;

    always_comb begin
        hit = 1'b1;
        unique case (paddr)
            ADDR_CTRL, ADDR_BO_TH1, ADDR_BO_TH2, ADDR_OC_TH1, ADDR_OC_TH2,
            ADDR_MON1, ADDR_MON2, ADDR_ALARM, ADDR_ISTAT, ADDR_IMASK: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !hit;

    // control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RST;
        end else if (wr_acc && paddr == ADDR_CTRL) begin
            ctrl <= pwdata[1:0];
        end
    end

    // channel 1 burnout threshold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr1.bo <= BO_TH_RST;
        end else if (wr_to(wr_acc, paddr, ADDR_BO_TH1)) begin
            thr1.bo <= clamp_th(pwdata);
        end
    end

    // channel 1 overcurrent threshold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr1.oc <= OC_TH_RST;
        end else if (wr_to(wr_acc, paddr, ADDR_OC_TH1)) begin
            thr1.oc <= clamp_th(pwdata);
        end
    end

    // channel 2 burnout threshold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr2.bo <= BO_TH_RST;
        end else if (wr_to(wr_acc, paddr, ADDR_BO_TH2)) begin
            thr2.bo <= clamp_th(pwdata);
        end
    end

    // channel 2 overcurrent threshold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr2.oc <= OC_TH_RST;
        end else if (wr_to(wr_acc, paddr, ADDR_OC_TH2)) begin
            thr2.oc <= clamp_th(pwdata);
        end
    end

    // channel 1 sample capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur1_q <= '0;
        end else if (sample_valid) begin
            cur1_q <= cur1;
        end
    end

    // channel 2 sample capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur2_q <= '0;
        end else if (sample_valid) begin
            cur2_q <= TWO_CT ? cur2 : '0;
        end
    end

    // channel 1 monitor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon1 <= 16'h0000;
        end else if (sample_valid) begin
            mon1 <= mon_val(cur1);
        end
    end

    // channel 2 monitor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon2 <= 16'h0000;
        end else if (sample_valid) begin
            mon2 <= TWO_CT ? mon_val(cur2) : 16'h0000;
        end
    end

    chac_on_timer #(
        .MIN_CYC (ON_MIN_CYC)
    ) u_timer (
        .pclk        (pclk),
        .presetn     (presetn),
        .heat_on     (heat_on),
        .long_enough (long_enough)
    );

    // evaluate one cycle after a sample, only on long enough on-time
    logic eval_pend;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eval_pend <= 1'b0;
        end else begin
            eval_pend <= sample_valid && long_enough;
        end
    end

    assign eval      = eval_pend;
    assign ch2_bo_en = TWO_CT && ctrl[CTRL_BO_EN];
    assign ch2_oc_en = TWO_CT && ctrl[CTRL_OC_EN];

    chac_chan_cmp u_ch1 (
        .pclk     (pclk),
        .presetn  (presetn),
        .cur      (cur1_q),
        .thr      (thr1),
        .bo_en    (ctrl[CTRL_BO_EN]),
        .oc_en    (ctrl[CTRL_OC_EN]),
        .eval     (eval),
        .bo_alarm (alarm.bo1),
        .oc_alarm (alarm.oc1)
    );

    chac_chan_cmp u_ch2 (
        .pclk     (pclk),
        .presetn  (presetn),
        .cur      (cur2_q),
        .thr      (thr2),
        .bo_en    (ch2_bo_en),
        .oc_en    (ch2_oc_en),
        .eval     (eval),
        .bo_alarm (alarm.bo2),
        .oc_alarm (alarm.oc2)
    );

    // edges of alarm onsets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_d <= '0;
        end else begin
            alarm_d <= alarm;
        end
    end

    assign rise = alarm & ~alarm_d;
    assign w1c  = (wr_acc && paddr == ADDR_ISTAT) ? chac_alarm_t'(pwdata[3:0]) : '0;

    // sticky status, set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat <= '0;
        end else begin
            istat <= (istat & ~w1c) | rise;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask <= IMASK_RST;
        end else if (wr_acc && paddr == ADDR_IMASK) begin
            imask <= chac_alarm_t'(pwdata[3:0]);
        end
    end

    assign irq = |(istat & imask);

    // blink period counter
    assign blink_wrap = (blink_cnt >= FLASH_CYC - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt <= 32'h0;
        end else if (blink_wrap) begin
            blink_cnt <= 32'h0;
        end else begin
            blink_cnt <= blink_cnt + 32'h1;
        end
    end

    // blink square wave for flashing monitors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink <= 1'b0;
        end else if (blink_wrap) begin
            blink <= ~blink;
        end
    end

    // lamp follows any alarm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            heater_alarm_lamp <= 1'b0;
        end else begin
            heater_alarm_lamp <= |alarm;
        end
    end

    // channel 1 monitor flash
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon1_flash <= 1'b0;
        end else begin
            mon1_flash <= (alarm.bo1 || alarm.oc1) && blink;
        end
    end

    // channel 2 monitor flash
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon2_flash <= 1'b0;
        end else begin
            mon2_flash <= (alarm.bo2 || alarm.oc2) && blink;
        end
    end

    // alarm output, any alarm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_out <= 1'b0;
        end else begin
            alarm_out <= |alarm;
        end
    end

    // read mux
    always_comb begin
        next_prdata = 32'h0;
        unique case (paddr)
            ADDR_CTRL:   next_prdata = 32'(ctrl);
            ADDR_BO_TH1: next_prdata = 32'(thr1.bo);
            ADDR_BO_TH2: next_prdata = 32'(thr2.bo);
            ADDR_OC_TH1: next_prdata = 32'(thr1.oc);
            ADDR_OC_TH2: next_prdata = 32'(thr2.oc);
            ADDR_MON1:   next_prdata = 32'(mon1);
            ADDR_MON2:   next_prdata = 32'(mon2);
            ADDR_ALARM:  next_prdata = 32'(alarm);
            ADDR_ISTAT:  next_prdata = 32'(istat);
            ADDR_IMASK:  next_prdata = 32'(imask);
            default:     next_prdata = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata <= next_prdata;
        end
    end

endmodule
`default_nettype wire

// ### verif/chac_monitor.sv
// checker: port-level assertions for the alarm compare block
`timescale 1ns/1ps
`default_nettype none
module chac_monitor
    import chac_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       heat_on,
    input wire logic       heater_alarm_lamp,
    input wire logic       alarm_out,
    input wire logic       mon1_flash,
    input wire logic       mon2_flash
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    assign mapped = (paddr <= ADDR_IMASK) && (paddr[1:0] == 2'h0);
    sequence quiet_s;
        (!heat_on && !psel) [*4];
    endsequence
    sequence dark_s;
        !alarm_out [*2];
    endsequence
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
        else $error("no error on unmapped access");
    chk_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
        else $error("error on mapped access");
    chk_err_setup: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access");
    chk_lamp_alarm: assert property (heater_alarm_lamp == alarm_out)
        else $error("lamp differs from alarm");
    chk_short_hold: assert property (quiet_s |=> $stable(alarm_out))
        else $error("alarm moved without evaluation");
    chk_flash_dark: assert property (dark_s |-> !mon1_flash && !mon2_flash)
        else $error("flash without alarm");
    chk_flash_blink: assert property (mon1_flash |-> ##[1:8] !mon1_flash)
        else $error("monitor 1 does not blink");
    chk_flash_lamp: assert property ($rose(mon2_flash) |-> alarm_out)
        else $error("monitor 2 flash without lamp");
endmodule
bind chac_top chac_monitor i_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .heat_on(heat_on),
    .heater_alarm_lamp(heater_alarm_lamp), .alarm_out(alarm_out),
    .mon1_flash(mon1_flash), .mon2_flash(mon2_flash)
);
`default_nettype wire

// ### verif/chac_ct_model.sv
// partner: current transformer front end handing samples to the block
`timescale 1ns/1ps
`default_nettype none
module chac_ct_model
    import chac_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             req,
    input  wire logic [CUR_W-1:0] c1,
    input  wire logic [CUR_W-1:0] c2,
    output logic                  sample_valid,
    output logic [CUR_W-1:0]      cur1,
    output logic [CUR_W-1:0]      cur2
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_valid <= 1'b0;
            cur1 <= '0;
            cur2 <= '0;
        end else if (req) begin
            sample_valid <= 1'b1;
            cur1 <= c1;
            cur2 <= c2;
        end else begin
            sample_valid <= 1'b0;
            cur1 <= ~cur1;
            cur2 <= ~cur2;
        end
    end
endmodule
`default_nettype wire

// ### verif/tb_heater_current_alarm_compare.sv
// testbench: alarm compare block against an integer reference model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((e) !== (s)) begin n_errors++; \
    $display("FAIL %s exp %h got %h", nm, e, s); end end
module tb_heater_current_alarm_compare import chac_pkg::*;;
    logic             pclk, presetn, psel, penable, pwrite, req, heat_on, er;
    logic             pready, pslverr, sample_valid, lamp, f1, f2, aout, irq;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, rd_v;
    logic [CUR_W-1:0] cur1, cur2, m1, m2;
    logic [15:0]      lf;
    int               n_errors, checks_done, ctrl, ca, cb;
    int               bt[2], ot[2], cl[2];
    chac_top #(.ON_MIN_CYC(8), .FLASH_CYC(2)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .sample_valid(sample_valid), .cur1(cur1), .cur2(cur2),
        .heat_on(heat_on), .heater_alarm_lamp(lamp), .mon1_flash(f1), .mon2_flash(f2),
        .alarm_out(aout), .irq(irq));
    chac_ct_model i_ct (.pclk(pclk), .presetn(presetn), .req(req), .c1(m1), .c2(m2),
        .sample_valid(sample_valid), .cur1(cur1), .cur2(cur2));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [3:0] exp_al();
        logic [3:0] a;
        for (int i = 0; i < 2; i++) begin
            a[2*i] = ctrl[0] && bt[i] != 0 && (bt[i] == 500 || cl[i] < bt[i]);
            a[2*i+1] = ctrl[1] && ot[i] != 500 && (ot[i] == 0 || cl[i] > ot[i]);
        end
        return a;
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_v = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, rd_v)
    endtask
    task automatic thr(input int i, input int oc, input int v);
        apb(1'b1, oc ? (i ? ADDR_OC_TH2 : ADDR_OC_TH1) : (i ? ADDR_BO_TH2 : ADDR_BO_TH1), v);
        if (oc) ot[i] = v > 500 ? 500 : v;
        else bt[i] = v > 500 ? 500 : v;
    endtask
    task automatic smp(input int c1, input int c2, input bit ev);
        @(posedge pclk);
        req <= 1'b1;
        m1 <= c1[9:0];
        m2 <= c2[9:0];
        @(posedge pclk);
        req <= 1'b0;
        if (ev) cl = '{c1, c2};
        repeat (6) @(posedge pclk);
    endtask
    task automatic chk_al();
        logic [3:0] ea;
        logic [1:0] fl;
        ea = exp_al();
        fl = 2'b00;
        rd(ADDR_ALARM, {28'h0, ea});
        repeat (4) begin
            @(negedge pclk);
            fl = fl | {f2, f1};
        end
        `CHK("lamp", |ea, lamp)
        `CHK("alarm out", |ea, aout)
        `CHK("flash", {|ea[3:2], |ea[1:0]}, fl)
        @(posedge pclk);
    endtask
    task automatic finish_test();
        $display("checks_done %0d n_errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge pclk);
        n_errors++;
        finish_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, req, heat_on, paddr, pwdata, m1, m2} = '0;
        n_errors = 0;
        checks_done = 0;
        ctrl = 0;
        bt = '{0, 0};
        ot = '{500, 500};
        cl = '{0, 0};
        lf = 16'h001C;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_BO_TH2, 32'h0);
        rd(ADDR_OC_TH1, 32'h1F4);
        rd(ADDR_IMASK, 32'h0);
        chk_al();
        apb(1'b0, 8'h30, 32'h0);
        `CHK("slverr", 1'b1, er)
        `CHK("unmapped", 32'h0, rd_v)
        apb(1'b1, ADDR_CTRL, 32'h3);
        ctrl = 3;
        apb(1'b1, ADDR_IMASK, 32'hF);
        heat_on <= 1'b1;
        repeat (12) @(posedge pclk);
        for (int k = 0; k < 10; k++) begin
            for (int i = 0; i < 4; i++) begin
                lf = lfsr(lf);
                thr(i % 2, i / 2, lf % 499 + 1);
            end
            lf = lfsr(lf);
            ca = (k % 2) ? bt[0] : (k == 4) ? 551 : (k == 6) ? 550 : lf % 600;
            lf = lfsr(lf);
            cb = (k % 2) ? ot[1] : lf % 600;
            smp(ca, cb, 1'b1);
            chk_al();
            rd(ADDR_MON1, ca > 550 ? 32'hFFFF : ca);
            rd(ADDR_MON2, cb > 550 ? 32'hFFFF : cb);
        end
        thr(0, 0, 600);
        rd(ADDR_BO_TH1, 32'h1F4);
        thr(1, 1, 0);
        repeat (3) @(posedge pclk);
        chk_al();
        thr(0, 0, 0);
        thr(1, 1, 500);
        repeat (3) @(posedge pclk);
        chk_al();
        apb(1'b1, ADDR_CTRL, 32'h1);
        ctrl = 1;
        thr(0, 1, 0);
        smp(100, 100, 1'b1);
        chk_al();
        apb(1'b1, ADDR_CTRL, 32'h3);
        ctrl = 3;
        thr(0, 0, 200);
        thr(1, 0, 200);
        smp(300, 300, 1'b1);
        heat_on <= 1'b0;
        smp(50, 50, 1'b0);
        chk_al();
        heat_on <= 1'b1;
        smp(50, 50, 1'b0);
        chk_al();
        repeat (10) @(posedge pclk);
        smp(50, 50, 1'b1);
        chk_al();
        apb(1'b1, ADDR_IMASK, 32'h0);
        apb(1'b1, ADDR_ISTAT, 32'hF);
        @(negedge pclk);
        `CHK("irq masked", 1'b0, irq)
        rd(ADDR_ISTAT, 32'h0);
        thr(0, 0, 0);
        apb(1'b1, ADDR_IMASK, 32'h1);
        thr(0, 0, 500);
        repeat (3) @(negedge pclk);
        `CHK("irq raised", 1'b1, irq)
        rd(ADDR_ISTAT, 32'h1);
        apb(1'b1, ADDR_ISTAT, 32'h1);
        @(negedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        chk_al();
        finish_test();
    end
endmodule
`default_nettype wire
